// ### core/hoi_pkg.sv
// constants shared by the host order and reply interface
package hoi_pkg;
    // widths and depths
    localparam int ORDER_W = 24;
    localparam int BYTE_W = 8;
    localparam int BYTES_PER_ORDER = 3;
    localparam int ORDER_DEPTH = 8;
    localparam int REPLY_W = 16;
    localparam int REPLY_DEPTH = 16;
    localparam int REPLY_AW = 4;
    localparam int FAIL_N = 4;
    localparam int REG_AW = 4;
    localparam int REG_DW = 8;

    // host command port map
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_FAIL = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // mode register fields
    localparam int MODE_MASTER_A = 0;
    localparam int MODE_MASTER_B = 1;
    localparam int MODE_LOCKOUT = 2;
    localparam int MODE_ANS_ACCESS = 3;
    localparam int MODE_DIVORCE = 4;
    localparam logic [4:0] MODE_RESET = 5'h00;

    // failure register fields
    localparam int FAIL_CPU0 = 0;
    localparam int FAIL_CPU1 = 1;
    localparam int FAIL_STORE = 2;
    localparam int FAIL_CORE = 3;
    localparam logic [3:0] FAIL_RESET = 4'h0;

    // status register fields
    localparam int STAT_EMPTY = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_ACCESS = 2;
    localparam int STAT_MASTER_MISMATCH = 3;
    localparam int STAT_COUNT_LSB = 4;

    // order byte sequencer
    typedef enum logic [1:0]
    {
        HOI_BYTE_0 = 2'b00,
        HOI_BYTE_1 = 2'b01,
        HOI_BYTE_2 = 2'b10
    } hoi_byte_sel_t;
endpackage

// ### core/hoi_host_port.sv
// host order queue, reply store and mode/failure flip-flops of one controller
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - host sets and reads five mode flip-flops
// - duplicated master; peripheral access needs both set
// - hardcore can set or clear master
// - lockout blocks hardcore master changes only
// - answer bus driven only with access set
// - divorce blocks order queue loading
// - host enables become queue write strobe
// - four failure flags, host readable
// - host or hardcore clears any failure flag
// - one fault flag per controller processor
// - reply store fault sets store flag
// - core comparator mismatch sets core flag
// - orders leave in arrival order
// - 24-bit orders in, 8-bit bytes out
// - hardcore writes 16-bit replies into store
// - host enable and address read replies
// - answer carries data, ok, parity, check bits
// - ok flag only for correct valid answer
// - drive out-of-service lamp output
// - parity bit set on even ones count
// - check bit pulsed on identify answers
module hoi_host_port
#(
    parameter int ORDER_DEPTH = hoi_pkg::ORDER_DEPTH,
    parameter int REPLY_DEPTH = hoi_pkg::REPLY_DEPTH
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // host command port
    input wire logic [hoi_pkg::REG_AW-1:0] i_reg_addr,
    input wire logic [hoi_pkg::REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [hoi_pkg::REG_DW-1:0] o_reg_rdata,
    // order address bus
    input wire logic [hoi_pkg::ORDER_W-1:0] i_order_data,
    input wire logic i_order_en_a,
    input wire logic i_order_en_b,
    // hardcore order unload
    input wire logic i_hc_order_rd,
    output logic [hoi_pkg::BYTE_W-1:0] o_hc_order_byte,
    output logic o_hc_order_valid,
    output logic o_order_empty,
    // hardcore mode and fault control
    input wire logic i_hc_master_set,
    input wire logic i_hc_master_clr,
    input wire logic [hoi_pkg::FAIL_N-1:0] i_hc_fail_clr,
    input wire logic [1:0] i_cpu_fault,
    input wire logic i_store_fault,
    input wire logic i_core_mismatch,
    // hardcore reply load
    input wire logic i_hc_reply_wr,
    input wire logic [hoi_pkg::REPLY_AW-1:0] i_hc_reply_addr,
    input wire logic [hoi_pkg::REPLY_W-1:0] i_hc_reply_data,
    // answer return bus
    input wire logic i_ans_rd,
    input wire logic i_ans_ident,
    input wire logic [hoi_pkg::REPLY_AW-1:0] i_ans_addr,
    output logic [hoi_pkg::REPLY_W-1:0] o_ans_data,
    output logic o_ans_ok,
    output logic o_ans_parity,
    output logic o_ans_check,
    output logic o_ans_oe_n,
    // peripheral and panel
    output logic o_periph_access,
    output logic o_oos_lamp,
    output logic [hoi_pkg::FAIL_N-1:0] o_fail_scan
);
    import hoi_pkg::*;

    localparam int QAW = $clog2(ORDER_DEPTH);
    localparam int RAW = $clog2(REPLY_DEPTH);

    // ----------------------------------------------------------------
    // mode flip-flops
    // ----------------------------------------------------------------
    logic [4:0] mode;
    logic host_mode_wr;
    logic hc_master_ok;

    assign host_mode_wr = i_reg_wr && (i_reg_addr == OFS_MODE);
    assign hc_master_ok = !mode[MODE_LOCKOUT];

    // host write wins over a hardcore request in the same cycle
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            mode <= MODE_RESET;
        end
        else if (host_mode_wr)
        begin
            mode <= i_reg_wdata[4:0];
        end
        else if (hc_master_ok && i_hc_master_set)
        begin
            mode[MODE_MASTER_A] <= 1'b1;
            mode[MODE_MASTER_B] <= 1'b1;
        end
        else if (hc_master_ok && i_hc_master_clr)
        begin
            mode[MODE_MASTER_A] <= 1'b0;
            mode[MODE_MASTER_B] <= 1'b0;
        end
    end

    // a single stuck copy cannot grant access on its own
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_periph_access <= 1'b0;
            o_oos_lamp <= 1'b1;
        end
        else
        begin
            o_periph_access <= mode[MODE_MASTER_A] && mode[MODE_MASTER_B];
            o_oos_lamp <= !(mode[MODE_MASTER_A] && mode[MODE_MASTER_B]);
        end
    end

    AST_LOCKOUT_HOLDS_MASTER:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (mode[MODE_LOCKOUT] && !host_mode_wr)
            |=> $stable(mode[MODE_MASTER_B:MODE_MASTER_A]))
        else $error("master changed under lockout");

    AST_HC_MASTER_SET:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (!mode[MODE_LOCKOUT] && !host_mode_wr && i_hc_master_set)
            |=> ##1 o_periph_access && !o_oos_lamp)
        else $error("hardcore master set not effective");

    AST_ACCESS_NEEDS_BOTH:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            o_periph_access |-> $past(mode[MODE_MASTER_A] && mode[MODE_MASTER_B]))
        else $error("peripheral access without both masters");

    // ----------------------------------------------------------------
    // failure flip-flops
    // ----------------------------------------------------------------
    logic [FAIL_N-1:0] fail;
    logic [FAIL_N-1:0] fail_set;
    logic [FAIL_N-1:0] fail_clr;

    assign fail_set[FAIL_CPU0] = i_cpu_fault[0];
    assign fail_set[FAIL_CPU1] = i_cpu_fault[1];
    assign fail_set[FAIL_CORE] = i_core_mismatch;
    assign fail_clr = i_hc_fail_clr
        | ((i_reg_wr && (i_reg_addr == OFS_FAIL)) ? i_reg_wdata[FAIL_N-1:0] : '0);

    generate
        for (genvar g = 0; g < FAIL_N; g++)
        begin : g_fail
            // a fault in the clear cycle is kept
            always_ff @(posedge i_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                begin
                    fail[g] <= FAIL_RESET[g];
                end
                else if (fail_set[g])
                begin
                    fail[g] <= 1'b1;
                end
                else if (fail_clr[g])
                begin
                    fail[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_fail_scan <= FAIL_RESET;
        end
        else
        begin
            o_fail_scan <= fail;
        end
    end

    AST_FAIL_SET_WINS:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            fail_set[FAIL_CORE] |=> ##1 o_fail_scan[FAIL_CORE])
        else $error("core mismatch not latched");

    AST_FAIL_CLEAR:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (i_hc_fail_clr[FAIL_CPU0] && !i_cpu_fault[0]) |=> !fail[FAIL_CPU0])
        else $error("hardcore clear ignored");

    // ----------------------------------------------------------------
    // order queue
    // ----------------------------------------------------------------
    logic [ORDER_W-1:0] queue_mem [ORDER_DEPTH];
    logic [QAW-1:0] wr_ptr;
    logic [QAW-1:0] rd_ptr;
    logic [QAW:0] q_count;
    logic q_full;
    logic q_empty;
    logic q_push;
    logic q_pop;
    logic byte_take;
    hoi_byte_sel_t byte_sel;
    hoi_byte_sel_t next_byte_sel;

    assign q_full = (q_count == (QAW+1)'(ORDER_DEPTH));
    assign q_empty = (q_count == '0);
    // both host enables needed; divorce and full inhibit the strobe
    assign q_push = i_order_en_a && i_order_en_b
        && !mode[MODE_DIVORCE] && !q_full;
    assign byte_take = i_hc_order_rd && !q_empty;
    assign q_pop = byte_take && (byte_sel == HOI_BYTE_2);

    always_ff @(posedge i_clk)
    begin
        if (q_push)
        begin
            queue_mem[wr_ptr] <= i_order_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            q_count <= '0;
        end
        else
        begin
            if (q_push)
            begin
                wr_ptr <= (wr_ptr == QAW'(ORDER_DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (q_pop)
            begin
                rd_ptr <= (rd_ptr == QAW'(ORDER_DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (q_push && !q_pop)
            begin
                q_count <= q_count + 1'b1;
            end
            else if (q_pop && !q_push)
            begin
                q_count <= q_count - 1'b1;
            end
        end
    end

    always_comb
    begin
        next_byte_sel = byte_sel;
        if (byte_take)
        begin
            unique case (byte_sel)
                HOI_BYTE_0: next_byte_sel = HOI_BYTE_1;
                HOI_BYTE_1: next_byte_sel = HOI_BYTE_2;
                HOI_BYTE_2: next_byte_sel = HOI_BYTE_0;
                default: next_byte_sel = HOI_BYTE_0;
            endcase
        end
    end

    // low byte of each order leaves first
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            byte_sel <= HOI_BYTE_0;
            o_hc_order_byte <= '0;
            o_hc_order_valid <= 1'b0;
            o_order_empty <= 1'b1;
        end
        else
        begin
            byte_sel <= next_byte_sel;
            o_hc_order_valid <= byte_take;
            o_order_empty <= (q_count == '0 && !q_push)
                || (q_count == (QAW+1)'(1) && q_pop && !q_push);
            if (byte_take)
            begin
                o_hc_order_byte <= queue_mem[rd_ptr][byte_sel*BYTE_W +: BYTE_W];
            end
        end
    end

    AST_DIVORCE_NO_LOAD:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (mode[MODE_DIVORCE] && !q_pop) |=> (q_count <= $past(q_count)))
        else $error("queue loaded while divorced");

    AST_FULL_KEEPS_COUNT:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (q_full && !q_pop) |=> q_full && $stable(wr_ptr))
        else $error("full queue overwritten");

    AST_EMPTY_NO_BYTE:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (i_hc_order_rd && q_empty) |=> !o_hc_order_valid && $stable(o_hc_order_byte))
        else $error("byte delivered from empty queue");

    // a half-read order must still sit in the queue
    AST_THREE_BYTES_PER_POP:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            (byte_sel != HOI_BYTE_0) |-> !q_empty)
        else $error("order popped before third byte");

    // ----------------------------------------------------------------
    // reply store and answer return bus
    // ----------------------------------------------------------------
    // each word keeps a stored parity so a corrupt cell shows on read
    logic [REPLY_W:0] reply_mem [REPLY_DEPTH];
    logic [REPLY_W:0] rd_word;
    logic rd_pending;
    logic rd_ident;
    logic rd_access;
    logic rd_bad;

    always_ff @(posedge i_clk)
    begin
        if (i_hc_reply_wr)
        begin
            reply_mem[i_hc_reply_addr[RAW-1:0]] <= {^i_hc_reply_data, i_hc_reply_data};
        end
        if (i_ans_rd)
        begin
            rd_word <= reply_mem[i_ans_addr[RAW-1:0]];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rd_pending <= 1'b0;
            rd_ident <= 1'b0;
            rd_access <= 1'b0;
        end
        else
        begin
            rd_pending <= i_ans_rd;
            rd_ident <= i_ans_rd && i_ans_ident;
            rd_access <= i_ans_rd && mode[MODE_ANS_ACCESS];
        end
    end

    // one stage added so every answer pin leaves a flip-flop
    assign rd_bad = rd_pending && (^rd_word);
    assign fail_set[FAIL_STORE] = i_store_fault || rd_bad;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_ans_data <= '0;
            o_ans_ok <= 1'b0;
            o_ans_parity <= 1'b0;
            o_ans_check <= 1'b0;
            o_ans_oe_n <= 1'b1;
        end
        else if (rd_access)
        begin
            o_ans_oe_n <= 1'b0;
            o_ans_data <= rd_word[REPLY_W-1:0];
            o_ans_ok <= !(^rd_word) && !fail[FAIL_STORE];
            o_ans_parity <= ~^rd_word[REPLY_W-1:0];
            o_ans_check <= rd_ident;
        end
        else
        begin
            o_ans_oe_n <= 1'b1;
            o_ans_data <= '0;
            o_ans_ok <= 1'b0;
            o_ans_parity <= 1'b0;
            o_ans_check <= 1'b0;
        end
    end

    AST_BUS_NEEDS_ACCESS:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            !o_ans_oe_n |-> $past(mode[MODE_ANS_ACCESS], 2) && $past(i_ans_rd, 2))
        else $error("answer bus driven without access");

    AST_PARITY_EVEN:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            !o_ans_oe_n |-> (o_ans_parity == ~^o_ans_data))
        else $error("answer parity wrong");

    AST_OK_ONLY_DRIVEN:
        assert property (@(posedge i_clk) disable iff (i_sys_rst)
            o_ans_ok |-> !o_ans_oe_n)
        else $error("ok flag on idle bus");

    // ----------------------------------------------------------------
    // host command port
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_reg_rdata <= '0;
        end
        else if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                OFS_MODE: o_reg_rdata <= {3'h0, mode};
                OFS_FAIL: o_reg_rdata <= {4'h0, fail};
                OFS_STATUS: o_reg_rdata <= {
                    q_count[3:0],
                    mode[MODE_MASTER_A] ^ mode[MODE_MASTER_B],
                    o_periph_access,
                    q_full,
                    q_empty};
                default: o_reg_rdata <= '0;
            endcase
        end
        else
        begin
            o_reg_rdata <= '0;
        end
    end
endmodule

`default_nettype wire

// ### tb/hoi_host_model.sv
// switching host model: drives orders and answer reads
`timescale 1ns/1ns
`default_nettype none
module hoi_host_model
(
    input wire logic i_clk,
    output logic [hoi_pkg::ORDER_W-1:0] o_order_data,
    output logic o_order_en_a,
    output logic o_order_en_b,
    output logic o_ans_rd,
    output logic o_ans_ident,
    output logic [hoi_pkg::REPLY_AW-1:0] o_ans_addr
);
    import hoi_pkg::*;
    initial
    begin
        o_order_data = 24'h00_0000;
        o_order_en_a = 1'b0;
        o_order_en_b = 1'b0;
        o_ans_rd = 1'b0;
        o_ans_ident = 1'b0;
        o_ans_addr = 4'h0;
    end
    // ----------------
    // order load, optionally after idle cycles
    // ----------------
    task automatic send_order(input logic [ORDER_W-1:0] d, input int idle);
        repeat (idle) @(posedge i_clk);
        @(posedge i_clk);
        o_order_data <= d;
        o_order_en_a <= 1'b1;
        o_order_en_b <= 1'b1;
        @(posedge i_clk);
        o_order_en_a <= 1'b0;
        o_order_en_b <= 1'b0;
        // released bus must not keep showing the order
        o_order_data <= ~d;
    endtask
    // ----------------
    // answer read; returns where the answer stands
    // ----------------
    task automatic read_answer(input logic [REPLY_AW-1:0] a, input logic id);
        @(posedge i_clk);
        o_ans_rd <= 1'b1;
        o_ans_addr <= a;
        o_ans_ident <= id;
        @(posedge i_clk);
        o_ans_rd <= 1'b0;
        o_ans_addr <= ~a;
        o_ans_ident <= ~id;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ### tb/hoi_host_port_bench.sv
// self-checking bench for the host order and reply port
`timescale 1ns/1ns
`default_nettype none
module hoi_host_port_bench;
    import hoi_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd, hc_order_rd, order_valid, order_empty;
    logic hc_master_set, hc_master_clr, store_fault, core_mismatch, hc_reply_wr;
    logic ans_rd, ans_ident, ans_ok, ans_parity, ans_check, ans_oe_n;
    logic periph_access, oos_lamp, order_en_a, order_en_b;
    logic [3:0] reg_addr, hc_fail_clr, hc_reply_addr, ans_addr, fail_scan;
    logic [7:0] reg_wdata, reg_rdata, order_byte;
    logic [23:0] order_data;
    logic [1:0] cpu_fault;
    logic [15:0] hc_reply_data, ans_data;
    int error_cnt = 0;
    int checked = 0;

    hoi_host_port dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_order_data(order_data), .i_order_en_a(order_en_a),
        .i_order_en_b(order_en_b), .i_hc_order_rd(hc_order_rd),
        .o_hc_order_byte(order_byte), .o_hc_order_valid(order_valid),
        .o_order_empty(order_empty), .i_hc_master_set(hc_master_set),
        .i_hc_master_clr(hc_master_clr), .i_hc_fail_clr(hc_fail_clr),
        .i_cpu_fault(cpu_fault), .i_store_fault(store_fault),
        .i_core_mismatch(core_mismatch), .i_hc_reply_wr(hc_reply_wr),
        .i_hc_reply_addr(hc_reply_addr), .i_hc_reply_data(hc_reply_data),
        .i_ans_rd(ans_rd), .i_ans_ident(ans_ident), .i_ans_addr(ans_addr),
        .o_ans_data(ans_data), .o_ans_ok(ans_ok), .o_ans_parity(ans_parity),
        .o_ans_check(ans_check), .o_ans_oe_n(ans_oe_n),
        .o_periph_access(periph_access), .o_oos_lamp(oos_lamp), .o_fail_scan(fail_scan));
    hoi_host_model host (.i_clk(clk), .o_order_data(order_data),
        .o_order_en_a(order_en_a), .o_order_en_b(order_en_b), .o_ans_rd(ans_rd),
        .o_ans_ident(ans_ident), .o_ans_addr(ans_addr));

    // ----------------
    // helpers
    // ----------------
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic hc_master(input logic s, input logic c);
        @(posedge clk);
        hc_master_set <= s;
        hc_master_clr <= c;
        @(posedge clk);
        hc_master_set <= 1'b0;
        hc_master_clr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic hc_byte(input logic [7:0] exp, input logic vexp);
        @(posedge clk);
        hc_order_rd <= 1'b1;
        @(posedge clk);
        hc_order_rd <= 1'b0;
        #1 chk(order_valid, vexp);
        if (vexp === 1'b1)
            chk(order_byte, exp);
    endtask
    task automatic ans_chk(input logic [3:0] a, input logic id, input logic [19:0] exp);
        host.read_answer(a, id);
        #1 chk({ans_oe_n, ans_ok, ans_parity, ans_check, ans_data}, exp);
    endtask
    task automatic fault(input logic [3:0] f, input logic [3:0] exp);
        @(posedge clk);
        {core_mismatch, store_fault, cpu_fault} <= f;
        @(posedge clk);
        {core_mismatch, store_fault, cpu_fault} <= 4'h0;
        @(posedge clk);
        #1 chk(fail_scan, exp);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset;
        chk({ans_oe_n, oos_lamp, order_empty, periph_access}, 4'hE);
        rd_chk(OFS_MODE, 8'h00);
        rd_chk(OFS_FAIL, 8'h00);
        rd_chk(OFS_STATUS, 8'h01);
        rd_chk(4'hC, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_mode;
        wr_reg(OFS_MODE, 8'h01);
        rd_chk(OFS_STATUS, 8'h09);
        chk({periph_access, oos_lamp}, 2'b01);
        wr_reg(OFS_MODE, 8'h03);
        rd_chk(OFS_STATUS, 8'h05);
        chk({periph_access, oos_lamp}, 2'b10);
        wr_reg(OFS_MODE, 8'h1F);
        rd_chk(OFS_MODE, 8'h1F);
        wr_reg(OFS_MODE, 8'h00);
        $display("test mode done");
    endtask
    task automatic t_master;
        hc_master(1'b1, 1'b0);
        chk(periph_access, 1'b1);
        rd_chk(OFS_MODE, 8'h03);
        hc_master(1'b0, 1'b1);
        chk(periph_access, 1'b0);
        wr_reg(OFS_MODE, 8'h04);
        hc_master(1'b1, 1'b0);
        chk(periph_access, 1'b0);
        wr_reg(OFS_MODE, 8'h07);
        hc_master(1'b0, 1'b1);
        chk(periph_access, 1'b1);
        wr_reg(OFS_MODE, 8'h00);
        $display("test master done");
    endtask
    task automatic t_order;
        int i;
        int b;
        logic [23:0] w;
        wr_reg(OFS_MODE, 8'h10);
        host.send_order(24'hA5_5A5A, 0);
        #1 chk(order_empty, 1'b1);
        wr_reg(OFS_MODE, 8'h00);
        for (i = 0; i < 9; i++)
            host.send_order(24'h30_2010 + 24'(i) * 24'h01_0101, i % 2);
        rd_chk(OFS_STATUS, 8'h82);
        for (i = 0; i < 8; i++)
        begin
            w = 24'h30_2010 + 24'(i) * 24'h01_0101;
            for (b = 0; b < 3; b++)
                hc_byte(w[8*b +: 8], 1'b1);
        end
        chk(order_empty, 1'b1);
        hc_byte(8'h00, 1'b0);
        chk(order_byte, 8'h37);
        $display("test order done");
    endtask
    task automatic t_answer;
        logic [3:0] a;
        for (a = 4'h1; a < 4'h4; a++)
        begin
            @(posedge clk);
            hc_reply_wr <= 1'b1;
            hc_reply_addr <= a;
            hc_reply_data <= (a == 4'h3) ? 16'h0000 : {12'h000, a};
            @(posedge clk);
            hc_reply_wr <= 1'b0;
        end
        ans_chk(4'h1, 1'b0, 20'h8_0000);
        wr_reg(OFS_MODE, 8'h08);
        ans_chk(4'h1, 1'b0, 20'h4_0001);
        ans_chk(4'h2, 1'b1, 20'h5_0002);
        ans_chk(4'h3, 1'b0, 20'h6_0000);
        @(posedge clk);
        #1 chk(ans_oe_n, 1'b1);
        $display("test answer done");
    endtask
    task automatic t_fail;
        fault(4'h1, 4'h1);
        fault(4'h2, 4'h3);
        fault(4'h4, 4'h7);
        ans_chk(4'h1, 1'b0, 20'h0_0001);
        fault(4'h8, 4'hF);
        rd_chk(OFS_FAIL, 8'h0F);
        wr_reg(OFS_FAIL, 8'h03);
        rd_chk(OFS_FAIL, 8'h0C);
        @(posedge clk);
        hc_fail_clr <= 4'h4;
        @(posedge clk);
        hc_fail_clr <= 4'h0;
        rd_chk(OFS_FAIL, 8'h08);
        $display("test fail done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------
    // run
    // ----------------
    always #5 clk = ~clk;
    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {reg_wr, reg_rd, hc_order_rd, hc_master_set, hc_master_clr} = 5'h00;
        {store_fault, core_mismatch, hc_reply_wr, cpu_fault} = 5'h00;
        {reg_addr, hc_fail_clr, hc_reply_addr} = 12'h000;
        reg_wdata = 8'h00;
        hc_reply_data = 16'h0000;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
        t_mode;
        t_master;
        t_order;
        t_answer;
        t_fail;
        summarize;
    end
    // hang guard, far above the under two hundred cycles the tests take
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize;
    end
endmodule
`default_nettype wire
